// ---- hdl/jog_axis_pkg.sv ----
// Purpose: shared constants and types for the manual jog / inching axis
// Assumes: 250 MHz core clock
// Notes: error and warning codes are decimal values held as hex
package jog_axis_pkg;
   localparam int CLK_HZ = 250_000_000;
   localparam int CLK_PERIOD_PS = 4000;
   // least times, rounded up to whole cycles
   localparam int T1_MIN_US = 1000;
   localparam int T3_MIN_US = 1300;
   localparam int INCH_PERIOD_US = 1800;
   localparam int T1_CYC = (T1_MIN_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int T3_CYC = (T3_MIN_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int INCH_CYC = (INCH_PERIOD_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TMR_W = 20;
   localparam int SPD_W = 32;
   localparam int INCH_W = 16;
   localparam int CODE_W = 16;
   localparam logic [SPD_W-1:0] JOG_SPEED_MIN = 32'h0000_0001;
   localparam logic [SPD_W-1:0] JOG_SPEED_MAX = 32'h003D_0900;
   localparam logic [CODE_W-1:0] ERR_JOG_SPEED_RANGE = 16'h012C;
   localparam logic [CODE_W-1:0] ERR_JOG_CEILING = 16'h03BC;
   localparam logic [CODE_W-1:0] WARN_JOG_SPEED_CLAMP = 16'h012D;
   localparam logic [CODE_W-1:0] ERR_HW_LIMIT = 16'h0068;
   localparam logic [CODE_W-1:0] ERR_SW_LIMIT = 16'h0069;
   localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
   localparam logic [TMR_W-1:0] TMR_ZERO = 20'h00000;
   localparam logic [INCH_W-1:0] INCH_ZERO = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_RUN,
      ST_DECEL,
      ST_STOP,
      ST_INCH,
      ST_HOLD
   } jog_state_e;
endpackage

// ---- hdl/pulse_rate_gen.sv ----
// Purpose: phase accumulator giving one tick per step at a rate in pulses/s
// Assumes: rate_i below half the clock rate
// Notes: accumulator clears while not running
`timescale 1ns/1ps
module pulse_rate_gen (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic run_i,
   input wire logic [31:0] rate_i,
   output logic tick_o
);
   typedef struct packed {
      logic [31:0] acc;
      logic tick;
   } rate_s;

   localparam logic [32:0] WRAP = 33'(jog_axis_pkg::CLK_HZ);

   rate_s cur_ff;
   rate_s nxt_cur;
   logic [32:0] sum;

   always_comb begin
      nxt_cur = cur_ff;
      sum = {1'b0, cur_ff.acc} + {1'b0, rate_i};
      nxt_cur.tick = 1'b0;
      if (!run_i) begin
         nxt_cur.acc = '0;
      end else if (sum >= WRAP) begin
         nxt_cur.acc = 32'(sum - WRAP);
         nxt_cur.tick = 1'b1;
      end else begin
         nxt_cur.acc = sum[31:0];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cur_ff <= '0;
      end else if (clk_en_i) begin
         cur_ff <= nxt_cur;
      end
   end

   assign tick_o = cur_ff.tick;
endmodule

// ---- hdl/manual_pulse_relay.sv ----
// Purpose: turns each rising edge of the hand-wheel pulse into one step
// Assumes: hand-wheel pulse and direction synchronous to the clock
// Notes: steps only while enabled
`timescale 1ns/1ps
module manual_pulse_relay (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic enable_i,
   input wire logic mpg_pulse_i,
   input wire logic mpg_dir_rev_i,
   output logic step_fwd_o,
   output logic step_rev_o
);
   typedef struct packed {
      logic last;
      logic fwd;
      logic rev;
   } relay_s;

   relay_s cur_ff;
   relay_s nxt_cur;
   logic edge_seen;

   always_comb begin
      nxt_cur = cur_ff;
      edge_seen = mpg_pulse_i && !cur_ff.last;
      nxt_cur.last = mpg_pulse_i;
      // one step per input edge while enable_i is high, none added; edges while disabled are dropped
      nxt_cur.fwd = enable_i && edge_seen && !mpg_dir_rev_i;
      nxt_cur.rev = enable_i && edge_seen && mpg_dir_rev_i;
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cur_ff <= '0;
      end else if (clk_en_i) begin
         cur_ff <= nxt_cur;
      end
   end

   assign step_fwd_o = cur_ff.fwd;
   assign step_rev_o = cur_ff.rev;
endmodule

// ---- hdl/manual_jog_inching_axis_control.sv ----
// Purpose: manual control of one axis: jog, inching and hand-wheel relay
// Assumes: requests and limit inputs synchronous to core_clk_i
// Notes: one-cycle step pulses on separate forward and reverse outputs
`timescale 1ns/1ps
module manual_jog_inching_axis_control #(
   parameter int START_CYC = jog_axis_pkg::T1_CYC,
   parameter int DECEL_CYC = jog_axis_pkg::T3_CYC,
   parameter int INCH_CYC = jog_axis_pkg::INCH_CYC
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic fwd_jog_i,
   input wire logic rev_jog_i,
   input wire logic [31:0] jog_speed_setting_i,
   input wire logic [31:0] jog_speed_ceiling_i,
   input wire logic [31:0] axis_speed_ceiling_i,
   input wire logic [15:0] inching_amount_setting_i,
   input wire logic mpg_enable_i,
   input wire logic mpg_pulse_i,
   input wire logic mpg_dir_rev_i,
   input wire logic upper_limit_ok_i,
   input wire logic lower_limit_ok_i,
   input wire logic signed [31:0] soft_upper_i,
   input wire logic signed [31:0] soft_lower_i,
   input wire logic err_reset_i,
   output logic pulse_fwd_o,
   output logic pulse_rev_o,
   output logic busy_o,
   output logic error_o,
   output logic [15:0] error_code_o,
   output logic warning_o,
   output logic [15:0] warning_code_o,
   output logic signed [31:0] position_o
);
   typedef struct packed {
      jog_axis_pkg::jog_state_e st;
      logic [jog_axis_pkg::TMR_W-1:0] tmr;
      logic [jog_axis_pkg::INCH_W-1:0] inch_left;
      logic dir_rev;
      logic [jog_axis_pkg::SPD_W-1:0] rate;
      logic signed [31:0] pos;
      logic pulse_fwd;
      logic pulse_rev;
      logic busy;
      logic err;
      logic [jog_axis_pkg::CODE_W-1:0] err_code;
      logic warn;
      logic [jog_axis_pkg::CODE_W-1:0] warn_code;
      logic pace;
   } jog_s;

   // last count of each timer
   localparam logic [jog_axis_pkg::TMR_W-1:0] START_LAST = jog_axis_pkg::TMR_W'(START_CYC - 1);
   localparam logic [jog_axis_pkg::TMR_W-1:0] DECEL_LAST = jog_axis_pkg::TMR_W'(DECEL_CYC - 1);
   localparam logic [jog_axis_pkg::TMR_W-1:0] INCH_LAST = jog_axis_pkg::TMR_W'(INCH_CYC - 1);

   jog_s cur_ff;
   jog_s nxt_cur;

   logic rate_run;
   logic [31:0] rate_eff;
   logic rate_tick;
   logic mpg_fwd;
   logic mpg_rev;
   logic mpg_allow;
   logic one_req;
   logic req_rev;
   logic req_held;
   logic fwd_block;
   logic rev_block;
   logic toward_block;
   logic [jog_axis_pkg::CODE_W-1:0] limit_code;
   logic step;

   ////////////////////////////////////////////////////////////////////////////
   // step sources

   assign rate_run = (cur_ff.st == jog_axis_pkg::ST_RUN) || (cur_ff.st == jog_axis_pkg::ST_DECEL);
   // half rate while slowing down
   assign rate_eff = (cur_ff.st == jog_axis_pkg::ST_DECEL) ? (cur_ff.rate >> 1) :
      cur_ff.rate;
   // hand-wheel only while the axis is otherwise still and clean
   assign mpg_allow = mpg_enable_i && (cur_ff.st == jog_axis_pkg::ST_IDLE) && !cur_ff.err;

   pulse_rate_gen u_rate (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .clk_en_i(clk_en_i),
      .run_i(rate_run),
      .rate_i(rate_eff),
      .tick_o(rate_tick)
   );

   manual_pulse_relay u_relay (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .clk_en_i(clk_en_i),
      .enable_i(mpg_allow),
      .mpg_pulse_i(mpg_pulse_i),
      .mpg_dir_rev_i(mpg_dir_rev_i),
      .step_fwd_o(mpg_fwd),
      .step_rev_o(mpg_rev)
   );

   ////////////////////////////////////////////////////////////////////////////
   // stroke limit view

   // both requests together start nothing
   assign one_req = fwd_jog_i ^ rev_jog_i;
   assign req_rev = rev_jog_i;
   assign fwd_block = !upper_limit_ok_i || (cur_ff.pos >= soft_upper_i);
   assign rev_block = !lower_limit_ok_i || (cur_ff.pos <= soft_lower_i);

   // idle judges the new request, a move its own direction
   always_comb begin
      toward_block = 1'b0;
      limit_code = jog_axis_pkg::ERR_SW_LIMIT;
      if (!cur_ff.dir_rev || (cur_ff.st == jog_axis_pkg::ST_IDLE && !req_rev)) begin
         toward_block = fwd_block;
         limit_code = upper_limit_ok_i ? jog_axis_pkg::ERR_SW_LIMIT : jog_axis_pkg::ERR_HW_LIMIT;
      end
      if (cur_ff.st == jog_axis_pkg::ST_IDLE ? req_rev : cur_ff.dir_rev) begin
         toward_block = rev_block;
         limit_code = lower_limit_ok_i ? jog_axis_pkg::ERR_SW_LIMIT : jog_axis_pkg::ERR_HW_LIMIT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence

   always_comb begin
      nxt_cur = cur_ff;
      // step outputs last one cycle
      nxt_cur.pulse_fwd = 1'b0;
      nxt_cur.pulse_rev = 1'b0;
      step = 1'b0;
      req_held = cur_ff.dir_rev ? rev_jog_i : fwd_jog_i;
      // a new error in the same cycle overrides the clear
      // warnings never gate motion
      if (err_reset_i) begin
         nxt_cur.err = 1'b0;
         nxt_cur.err_code = jog_axis_pkg::CODE_NONE;
         nxt_cur.warn = 1'b0;
         nxt_cur.warn_code = jog_axis_pkg::CODE_NONE;
      end
      unique case (cur_ff.st)
         jog_axis_pkg::ST_IDLE: begin
            if (one_req && !cur_ff.err) begin
               nxt_cur.dir_rev = req_rev;
               // ceiling first, then speed range, then stroke limit
               if (jog_speed_ceiling_i > axis_speed_ceiling_i) begin
                  nxt_cur.err = 1'b1;
                  nxt_cur.err_code = jog_axis_pkg::ERR_JOG_CEILING;
               end else if (jog_speed_setting_i < jog_axis_pkg::JOG_SPEED_MIN ||
                     jog_speed_setting_i > jog_axis_pkg::JOG_SPEED_MAX) begin
                  nxt_cur.err = 1'b1;
                  nxt_cur.err_code = jog_axis_pkg::ERR_JOG_SPEED_RANGE;
               end else if (toward_block) begin
                  // refused again toward the limit after a reset
                  nxt_cur.err = 1'b1;
                  nxt_cur.err_code = limit_code;
               end else begin
                  if (jog_speed_setting_i > jog_speed_ceiling_i) begin
                     nxt_cur.rate = jog_speed_ceiling_i;
                     nxt_cur.warn = 1'b1;
                     nxt_cur.warn_code = jog_axis_pkg::WARN_JOG_SPEED_CLAMP;
                  end else begin
                     nxt_cur.rate = jog_speed_setting_i;
                  end
                  nxt_cur.busy = 1'b1;
                  nxt_cur.tmr = jog_axis_pkg::TMR_ZERO;
                  nxt_cur.inch_left = inching_amount_setting_i;
                  nxt_cur.pace = 1'b0;
                  nxt_cur.st = jog_axis_pkg::ST_START;
               end
            end else if (mpg_fwd || mpg_rev) begin
               // hand-wheel steps leave busy low
               nxt_cur.pulse_fwd = mpg_fwd;
               nxt_cur.pulse_rev = mpg_rev;
               nxt_cur.dir_rev = mpg_rev;
               step = 1'b1;
            end
         end
         jog_axis_pkg::ST_START: begin
            // hold off the first step by the start delay
            if (!req_held) begin
               // dropped early: end without a step
               nxt_cur.st = jog_axis_pkg::ST_STOP;
            end else if (cur_ff.tmr == START_LAST) begin
               nxt_cur.tmr = jog_axis_pkg::TMR_ZERO;
               if (cur_ff.inch_left != jog_axis_pkg::INCH_ZERO) begin
                  nxt_cur.st = jog_axis_pkg::ST_INCH;
               end else begin
                  nxt_cur.st = jog_axis_pkg::ST_RUN;
               end
            end else begin
               nxt_cur.tmr = cur_ff.tmr + 1'b1;
            end
         end
         jog_axis_pkg::ST_RUN: begin
            // a limit reached mid-move stops at once
            if (toward_block) begin
               nxt_cur.err = 1'b1;
               nxt_cur.err_code = limit_code;
               nxt_cur.st = jog_axis_pkg::ST_STOP;
            end else if (!req_held) begin
               nxt_cur.tmr = jog_axis_pkg::TMR_ZERO;
               nxt_cur.st = jog_axis_pkg::ST_DECEL;
            end else if (rate_tick) begin
               step = 1'b1;
            end
         end
         jog_axis_pkg::ST_DECEL: begin
            // run out the stop time at half rate
            if (toward_block) begin
               nxt_cur.err = 1'b1;
               nxt_cur.err_code = limit_code;
               nxt_cur.st = jog_axis_pkg::ST_STOP;
            end else if (cur_ff.tmr == DECEL_LAST) begin
               nxt_cur.st = jog_axis_pkg::ST_STOP;
            end else begin
               nxt_cur.tmr = cur_ff.tmr + 1'b1;
               step = rate_tick;
            end
         end
         jog_axis_pkg::ST_STOP: begin
            // busy drops one cycle after the stop state is entered
            nxt_cur.busy = 1'b0;
            nxt_cur.st = jog_axis_pkg::ST_HOLD;
         end
         jog_axis_pkg::ST_INCH: begin
            // steps on alternate cycles, then wait out the interval
            if (cur_ff.inch_left != jog_axis_pkg::INCH_ZERO && !toward_block) begin
               nxt_cur.pace = !cur_ff.pace;
               if (!cur_ff.pace) begin
                  step = 1'b1;
                  nxt_cur.inch_left = cur_ff.inch_left - 1'b1;
               end
            end else if (cur_ff.inch_left != jog_axis_pkg::INCH_ZERO) begin
               // limit reached before the amount was sent
               nxt_cur.err = 1'b1;
               nxt_cur.err_code = limit_code;
               nxt_cur.st = jog_axis_pkg::ST_STOP;
            end
            if (cur_ff.tmr == INCH_LAST) begin
               nxt_cur.st = jog_axis_pkg::ST_STOP;
            end else begin
               nxt_cur.tmr = cur_ff.tmr + 1'b1;
            end
         end
         jog_axis_pkg::ST_HOLD: begin
            // one move per request: wait for both requests to drop
            if (!fwd_jog_i && !rev_jog_i) begin
               nxt_cur.st = jog_axis_pkg::ST_IDLE;
            end
         end
      endcase
      if (step && cur_ff.st != jog_axis_pkg::ST_IDLE) begin
         nxt_cur.pulse_fwd = !cur_ff.dir_rev;
         nxt_cur.pulse_rev = cur_ff.dir_rev;
      end
      // position follows emitted steps only
      if (nxt_cur.pulse_fwd) begin
         nxt_cur.pos = cur_ff.pos + 32'sh0000_0001;
      end else if (nxt_cur.pulse_rev) begin
         nxt_cur.pos = cur_ff.pos - 32'sh0000_0001;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cur_ff <= '0;
      end else if (clk_en_i) begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign pulse_fwd_o = cur_ff.pulse_fwd;
   assign pulse_rev_o = cur_ff.pulse_rev;
   assign busy_o = cur_ff.busy;
   assign error_o = cur_ff.err;
   assign error_code_o = cur_ff.err_code;
   assign warning_o = cur_ff.warn;
   assign warning_code_o = cur_ff.warn_code;
   assign position_o = cur_ff.pos;
endmodule

// ---- verification/jog_axis_checker.sv ----
// Purpose: port-level checks for the manual jog axis
// Assumes: clock enable held high by the bench
// Notes: bound to the top module below
`timescale 1ns/1ps
module jog_axis_checker #(
   parameter int START_CYC = 20,
   parameter int DECEL_CYC = 30,
   parameter int INCH_CYC = 200
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic fwd_jog_i,
   input wire logic rev_jog_i,
   input wire logic [15:0] inching_amount_setting_i,
   input wire logic mpg_enable_i,
   input wire logic mpg_pulse_i,
   input wire logic mpg_dir_rev_i,
   input wire logic err_reset_i,
   input wire logic pulse_fwd_o,
   input wire logic pulse_rev_o,
   input wire logic busy_o,
   input wire logic error_o,
   input wire logic [15:0] error_code_o,
   input wire logic warning_o,
   input wire logic [15:0] warning_code_o
);
   localparam int BUSY_MAX = START_CYC + DECEL_CYC + INCH_CYC + 8;
   localparam int GAP_MAX = START_CYC + 300;
   logic [31:0] gap_ff;
   logic [31:0] mv_ff;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////////////////////
   // cycles since the last forward step of a held jog; steps within a move
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !(fwd_jog_i && busy_o) || pulse_fwd_o) begin
         gap_ff <= 32'h0;
      end else begin
         gap_ff <= gap_ff + 32'h1;
      end
      if (srst_i || !busy_o) begin
         mv_ff <= 32'h0;
      end else if (pulse_fwd_o || pulse_rev_o) begin
         mv_ff <= mv_ff + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   AST_NO_BOTH: assert property (!(pulse_fwd_o && pulse_rev_o))
      else $error("forward and reverse step together");
   AST_JOG_GAP: assert property ((inching_amount_setting_i == 16'h0000 && !error_o)
      |-> gap_ff <= GAP_MAX) else $error("held jog stopped stepping");
   AST_INCH_COUNT: assert property ((inching_amount_setting_i != 16'h0000 && busy_o)
      |-> mv_ff <= {16'h0000, inching_amount_setting_i}) else $error("inching overran");
   AST_SPEED_ERR: assert property ((error_o
      && (error_code_o == jog_axis_pkg::ERR_JOG_SPEED_RANGE
      || error_code_o == jog_axis_pkg::ERR_JOG_CEILING))
      |-> !pulse_fwd_o && !pulse_rev_o && !busy_o) else $error("motion despite speed error");
   AST_WARN_CODE: assert property (warning_o
      |-> warning_code_o == jog_axis_pkg::WARN_JOG_SPEED_CLAMP) else $error("bad warning code");
   AST_ERR_CLEAR: assert property ((err_reset_i && !fwd_jog_i && !rev_jog_i && !busy_o
      && !mpg_pulse_i) |=> !error_o && !warning_o) else $error("error not cleared");
   AST_MPG_STEP: assert property (($rose(mpg_pulse_i) && mpg_enable_i && !busy_o && !error_o
      && !fwd_jog_i && !rev_jog_i) |-> ##2 (pulse_fwd_o != pulse_rev_o)
      && (pulse_rev_o == $past(mpg_dir_rev_i, 2))) else $error("hand-wheel step missing");
   AST_START_QUIET: assert property ($rose(busy_o)
      |-> (!pulse_fwd_o && !pulse_rev_o)[*8]) else $error("step too soon after start");
   AST_BUSY_END: assert property ((busy_o && !fwd_jog_i && !rev_jog_i)
      |-> ##[0:BUSY_MAX] !busy_o) else $error("busy did not clear");
   AST_HOST_MOTION: assert property (((pulse_fwd_o || pulse_rev_o) && !mpg_enable_i)
      |-> busy_o) else $error("step outside a move");
endmodule
bind manual_jog_inching_axis_control jog_axis_checker #(.START_CYC(START_CYC),
   .DECEL_CYC(DECEL_CYC), .INCH_CYC(INCH_CYC)) chk_i (.core_clk_i(core_clk_i),
   .srst_i(srst_i), .fwd_jog_i(fwd_jog_i), .rev_jog_i(rev_jog_i),
   .inching_amount_setting_i(inching_amount_setting_i), .mpg_enable_i(mpg_enable_i),
   .mpg_pulse_i(mpg_pulse_i), .mpg_dir_rev_i(mpg_dir_rev_i), .err_reset_i(err_reset_i),
   .pulse_fwd_o(pulse_fwd_o), .pulse_rev_o(pulse_rev_o), .busy_o(busy_o), .error_o(error_o),
   .error_code_o(error_code_o), .warning_o(warning_o), .warning_code_o(warning_code_o));

// ---- verification/drive_unit_model.sv ----
// Purpose: motor drive unit that counts the step pulses it receives
// Assumes: one-cycle step pulses
// Notes: position follows forward minus reverse steps
`timescale 1ns/1ps
module drive_unit_model (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic pulse_fwd_i,
   input wire logic pulse_rev_i,
   output logic [31:0] fwd_cnt_o,
   output logic [31:0] rev_cnt_o,
   output logic signed [31:0] pos_o
);
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         fwd_cnt_o <= 32'h0;
         rev_cnt_o <= 32'h0;
         pos_o <= 32'sh0;
      end else begin
         fwd_cnt_o <= fwd_cnt_o + {31'h0, pulse_fwd_i};
         rev_cnt_o <= rev_cnt_o + {31'h0, pulse_rev_i};
         pos_o <= pos_o + $signed({31'h0, pulse_fwd_i}) - $signed({31'h0, pulse_rev_i});
      end
   end
endmodule

// ---- verification/tb.sv ----
// Purpose: self-checking bench for the manual jog axis
// Assumes: shortened start, stop and inching counts
// Notes: clock enable held high throughout
`timescale 1ns/1ps
module tb;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic fwd = 1'b0;
   logic rev = 1'b0;
   logic [31:0] spd = jog_axis_pkg::JOG_SPEED_MAX;
   logic [31:0] jcl = jog_axis_pkg::JOG_SPEED_MAX;
   logic [31:0] acl = jog_axis_pkg::JOG_SPEED_MAX;
   logic [15:0] inch = 16'h0000;
   logic mpg_en = 1'b0;
   logic mpg_p = 1'b0;
   logic mpg_d = 1'b0;
   logic up_ok = 1'b1;
   logic lo_ok = 1'b1;
   logic signed [31:0] sup = 32'sh7FFF_FFFF;
   logic signed [31:0] slo = 32'sh8000_0000;
   logic erst = 1'b0;
   logic pf, pr, busy, err, warn;
   logic [15:0] ecode, wcode;
   logic signed [31:0] pos, mpos;
   logic [31:0] fcnt, rcnt;
   int num_errors = 0;
   int checked = 0;
   always #2 core_clk_i = ~core_clk_i;
   manual_jog_inching_axis_control #(.START_CYC(20), .DECEL_CYC(30), .INCH_CYC(200)) dut (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .clk_en_i(1'b1), .fwd_jog_i(fwd),
      .rev_jog_i(rev), .jog_speed_setting_i(spd), .jog_speed_ceiling_i(jcl),
      .axis_speed_ceiling_i(acl), .inching_amount_setting_i(inch), .mpg_enable_i(mpg_en),
      .mpg_pulse_i(mpg_p), .mpg_dir_rev_i(mpg_d), .upper_limit_ok_i(up_ok),
      .lower_limit_ok_i(lo_ok), .soft_upper_i(sup), .soft_lower_i(slo),
      .err_reset_i(erst), .pulse_fwd_o(pf), .pulse_rev_o(pr), .busy_o(busy), .error_o(err),
      .error_code_o(ecode), .warning_o(warn), .warning_code_o(wcode), .position_o(pos));
   drive_unit_model drv (.core_clk_i(core_clk_i), .srst_i(srst_i), .pulse_fwd_i(pf),
      .pulse_rev_i(pr), .fwd_cnt_o(fcnt), .rev_cnt_o(rcnt), .pos_o(mpos));
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (num_errors == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 3000) begin
         step(1);
         k++;
      end
      chk({31'h0, busy}, 32'h0);
      // a quiet cycle lets the hold state return to idle
      step(1);
   endtask
   task automatic clear_err;
      erst = 1'b1;
      step(1);
      erst = 1'b0;
      step(1);
      chk({30'h0, err, warn}, 32'h0);
   endtask
   task automatic start_err(input logic dir_rev, input logic [15:0] code);
      fwd = !dir_rev;
      rev = dir_rev;
      step(3);
      chk({30'h0, err, busy}, 32'h2);
      chk({16'h0000, ecode}, {16'h0000, code});
      fwd = 1'b0;
      rev = 1'b0;
      step(2);
      clear_err();
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_jog;
      logic [31:0] f0;
      f0 = fcnt;
      fwd = 1'b1;
      step(3);
      chk({31'h0, busy}, 32'h1);
      step(400);
      chk({31'h0, (fcnt - f0) >= 32'h4}, 32'h1);
      fwd = 1'b0;
      wait_idle();
      chk(pos, mpos);
   endtask
   task automatic t_warn;
      logic [31:0] r0;
      r0 = rcnt;
      jcl = 32'h001E_8480;
      rev = 1'b1;
      step(3);
      chk({31'h0, warn}, 32'h1);
      chk({16'h0000, wcode}, 32'h0000_012D);
      step(600);
      chk({31'h0, (rcnt - r0) >= 32'h3}, 32'h1);
      rev = 1'b0;
      wait_idle();
      clear_err();
      jcl = jog_axis_pkg::JOG_SPEED_MAX;
   endtask
   task automatic t_speed_err;
      spd = 32'h0000_0000;
      start_err(1'b0, jog_axis_pkg::ERR_JOG_SPEED_RANGE);
      spd = 32'h003D_0901;
      start_err(1'b1, jog_axis_pkg::ERR_JOG_SPEED_RANGE);
      spd = jog_axis_pkg::JOG_SPEED_MAX;
      jcl = 32'h003D_0901;
      start_err(1'b0, jog_axis_pkg::ERR_JOG_CEILING);
      jcl = jog_axis_pkg::JOG_SPEED_MAX;
   endtask
   task automatic t_inch(input logic dir_rev, input logic [15:0] n);
      logic [31:0] c0;
      c0 = fcnt + rcnt;
      inch = n;
      fwd = !dir_rev;
      rev = dir_rev;
      step(3);
      wait_idle();
      chk(fcnt + rcnt - c0, {16'h0000, n});
      fwd = 1'b0;
      rev = 1'b0;
      inch = 16'h0000;
      step(2);
   endtask
   task automatic t_mpg;
      logic [31:0] f0;
      logic [31:0] r0;
      f0 = fcnt;
      r0 = rcnt;
      mpg_en = 1'b1;
      for (int i = 0; i < 9; i++) begin
         mpg_d = (i >= 6);
         mpg_p = 1'b1;
         step(2);
         mpg_p = 1'b0;
         step(2);
      end
      step(4);
      chk(fcnt - f0, 32'h6);
      chk(rcnt - r0, 32'h3);
      mpg_en = 1'b0;
   endtask
   task automatic t_limit;
      logic [31:0] r0;
      up_ok = 1'b0;
      start_err(1'b0, jog_axis_pkg::ERR_HW_LIMIT);
      r0 = rcnt;
      rev = 1'b1;
      step(300);
      rev = 1'b0;
      wait_idle();
      chk({31'h0, (rcnt - r0) >= 32'h2}, 32'h1);
      chk({31'h0, err}, 32'h0);
      start_err(1'b0, jog_axis_pkg::ERR_HW_LIMIT);
      up_ok = 1'b1;
      lo_ok = 1'b0;
      start_err(1'b1, jog_axis_pkg::ERR_HW_LIMIT);
      lo_ok = 1'b1;
      sup = mpos;
      start_err(1'b0, jog_axis_pkg::ERR_SW_LIMIT);
      sup = 32'sh7FFF_FFFF;
      slo = mpos;
      start_err(1'b1, jog_axis_pkg::ERR_SW_LIMIT);
      slo = 32'sh8000_0000;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      step(16);
      srst_i = 1'b0;
      step(1);
      t_jog();
      t_warn();
      t_speed_err();
      t_inch(1'b0, 16'h0005);
      t_inch(1'b1, 16'h0001);
      t_mpg();
      t_limit();
      give_verdict();
   end
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end
endmodule
